// *** hw/ecc_csr_decode.sv ***
// Control-location decoder of the ECC memory board on the slave bus
// Summary of operation
// - Switch segment one is ignored entirely.
// - Segments two..five pick board 0..3.
// - Closed segment reads on, open reads off.
// - Segments six..eight compare against A31-A29.
// - Open decode segments pull high, match 111.
// - Decode needs board, top match, new strobe; A2 only picks the register.
// - A2 low selects the board control register.
// - A2 high write loads diagnostic latches.
// - A2 high read starts check bit init.
// - Latches write-only, both chips written together.
`timescale 1ns/10ps
module ecc_csr_decode #(
    parameter int DATA_WIDTH = ecc_decode_pkg::DATA_W
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_ecc_board_config_switch,
    input wire logic i_cyc,
    input wire logic i_we,
    input wire logic [ecc_decode_pkg::ADDR_W-1:0] i_addr,
    input wire logic [DATA_WIDTH-1:0] i_wdata,
    output logic o_ack,
    output logic [DATA_WIDTH-1:0] o_rdata,
    output logic [DATA_WIDTH-1:0] o_csr,
    output logic [DATA_WIDTH-1:0] o_diag_a,
    output logic [DATA_WIDTH-1:0] o_diag_b,
    output logic o_check_init,
    output logic o_board_valid
);
    import ecc_decode_pkg::*;

    initial begin
        if (DATA_WIDTH != 32) $error("DATA_WIDTH must be 32");
    end

    // Segment is on when closed; switch input is 1 when closed
    function automatic logic seg_on(input logic [7:0] sw, input int idx);
        return sw[idx];
    endfunction

    // Board number from the first closed board segment
    function automatic logic [2:0] board_of(input logic [7:0] sw);
        logic [2:0] r;
        r = 3'h4;
        for (int k = SEG_BOARD_HI; k >= SEG_BOARD_LO; k--) begin
            if (seg_on(sw, k)) begin
                r = 3'(k - SEG_BOARD_LO);
            end
        end
        return r;
    endfunction

    typedef struct packed {
        logic ack;
        logic [DATA_WIDTH-1:0] rdata;
        logic [DATA_WIDTH-1:0] csr;
        logic check_init;
        logic board_valid;
        logic prev_cyc;
    } dec_state_type;

    dec_state_type s_q;
    dec_state_type s_d;

    logic [2:0] board_num;
    logic [2:0] dec_bits;
    logic top_match;
    logic brd_match;
    logic hit;
    logic diag_we;
    logic new_cyc;

    // Segment one is deliberately never read
    assign board_num = board_of(i_ecc_board_config_switch);
    // Open segment = off = pulled high, so all-open matches 111
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            dec_bits[2-k] = !seg_on(i_ecc_board_config_switch,
                SEG_DEC_LO + k);
        end
    end
    assign top_match = (i_addr[ADDR_TOP_HI:ADDR_TOP_LO] == dec_bits);
    // Board 0 sits highest in the window, as the default map does
    assign brd_match = (board_num[2] == 1'b0) &&
        (i_addr[ADDR_BRD_HI:ADDR_BRD_LO] == ~board_num[1:0]);
    assign new_cyc = i_cyc && !s_q.prev_cyc;
    assign hit = new_cyc && brd_match && top_match;
    assign diag_we = hit && i_addr[ADDR_SEL_BIT] && i_we;

    // One access per cycle edge; a held strobe answers once
    always_comb begin
        s_d = s_q;
        s_d.prev_cyc = i_cyc;
        s_d.ack = hit;
        s_d.check_init = 1'b0;
        s_d.board_valid = !board_num[2];
        s_d.rdata = '0;
        if (hit && !i_addr[ADDR_SEL_BIT]) begin
            if (i_we) begin
                s_d.csr = i_wdata;
            end else begin
                s_d.rdata = s_q.csr;
            end
        end
        // Latches are write-only; a read kicks initialization instead
        if (hit && i_addr[ADDR_SEL_BIT] && !i_we) begin
            s_d.check_init = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.csr <= CSR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ecc_diag_latch #(
        .WIDTH(DATA_WIDTH)
    ) u_latch (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(diag_we),
        .i_data(i_wdata),
        .o_latch_a(o_diag_a),
        .o_latch_b(o_diag_b)
    );

    assign o_ack = s_q.ack;
    assign o_rdata = s_q.rdata;
    assign o_csr = s_q.csr;
    assign o_check_init = s_q.check_init;
    assign o_board_valid = s_q.board_valid;

    sequence diag_read_s;
        new_cyc && !i_we && i_addr[ADDR_SEL_BIT] && brd_match && top_match;
    endsequence

    no_match_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (new_cyc && !(brd_match && top_match)) |=> !o_ack)
        else $error("ack without decode match");
    match_ack_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (new_cyc && brd_match && top_match) |=> o_ack)
        else $error("decoded access not acknowledged");
    init_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        diag_read_s |=> o_check_init && o_rdata == '0)
        else $error("latch read did not start init");
    init_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_check_init |-> $past(hit) && $past(!i_we))
        else $error("init without latch read");
    csr_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (hit && i_we && !i_addr[ADDR_SEL_BIT]) |=>
        o_csr == $past(i_wdata))
        else $error("control register not written");
    diag_keep_csr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        diag_we |=> $stable(o_csr) && o_diag_a == $past(i_wdata))
        else $error("latch write misrouted");
    open_match_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ecc_board_config_switch[7:5] == 3'h0) |->
        (top_match == (i_addr[31:29] == 3'h7)))
        else $error("open segments do not match 111");
    seg_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $changed(i_ecc_board_config_switch[0]) &&
        $stable(i_ecc_board_config_switch[7:1]) |-> $stable(board_num))
        else $error("segment one affected board");

    // The checks below follow one access from its taking edge to its
    // answer. The strobe is edge detected, so the decoded-access sequences are
    // framed around the first cycle in which i_cyc is seen high. A held strobe
    // must never produce a second answer, or software that polls the
    // control register would read it twice and count two events.
    // Diagnostic latches are write-only: no read path exists, and a read
    // of their location is a command, not a data transfer. The decode
    // segments work as inverted address bits because an open segment is
    // pulled high; a closed one drives the compare bit low.

    // Strobe low, then high with a full decode match
    sequence access_s;
        !i_cyc ##1 (i_cyc && brd_match && top_match);
    endsequence
    // Strobe seen high on two edges in a row
    sequence held_s;
        i_cyc ##1 i_cyc;
    endsequence
    // Decoded write to the control register
    sequence csr_write_s;
        hit && i_we && !i_addr[ADDR_SEL_BIT];
    endsequence
    // Decoded read of the control register
    sequence csr_read_s;
        hit && !i_we && !i_addr[ADDR_SEL_BIT];
    endsequence
    // Decoded write to the latch pair
    sequence diag_write_s;
        hit && i_we && i_addr[ADDR_SEL_BIT];
    endsequence
    // New strobe that fails the decode
    sequence miss_s;
        new_cyc && !(brd_match && top_match);
    endsequence

    // A full match after an idle cycle is always answered
    access_ack_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        access_s |=> o_ack)
        else $error("matched access not answered");
    // A held strobe is one access, never two
    held_cyc_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        held_s |=> !o_ack)
        else $error("held strobe answered again");
    // Answer is a single-cycle pulse
    ack_pulse_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_ack |=> !o_ack)
        else $error("ack longer than one cycle");
    // Init start is a single-cycle pulse
    init_pulse_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_check_init |=> !o_check_init)
        else $error("init pulse longer than one cycle");
    // Init only ever starts on an answered access
    init_with_ack_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_check_init |-> o_ack)
        else $error("init without an answer");
    // Read data is zero outside an answer, so nothing leaks
    rdata_idle_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !o_ack |-> o_rdata == '0)
        else $error("read data outside an answer");
    // A control register read returns its contents
    csr_read_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        csr_read_s |=> o_rdata == $past(o_csr) && !o_check_init)
        else $error("control register read wrong");
    // Control register holds unless written
    csr_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !(hit && i_we && !i_addr[ADDR_SEL_BIT]) |=> $stable(o_csr))
        else $error("control register changed unasked");
    // A control register write leaves the latches alone
    a2_low_no_diag_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        csr_write_s |=> $stable(o_diag_a) && $stable(o_diag_b))
        else $error("control write reached latches");
    // Latch write is answered with no data and no init
    diag_write_ack_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        diag_write_s |=> o_ack && !o_check_init && o_rdata == '0)
        else $error("latch write answered wrongly");
    // Latches hold unless written
    diag_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !diag_we |=> $stable(o_diag_a) && $stable(o_diag_b))
        else $error("latches changed unasked");
    // Both chips always carry the same pattern
    diag_pair_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_diag_a == o_diag_b)
        else $error("latch pair differs");
    // A latch read is a command and changes no stored value
    diag_read_keep_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        diag_read_s |=> $stable(o_diag_a) && $stable(o_csr))
        else $error("latch read altered state");
    // A refused access changes nothing
    miss_keep_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        miss_s |=> $stable(o_csr) && $stable(o_diag_a) && !o_check_init)
        else $error("refused access changed state");
    // No board segment closed means no answer at all
    no_board_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (new_cyc && board_num[2]) |=> !o_ack)
        else $error("answer with no board selected");
    // Top bits that miss the decode are refused
    top_miss_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (new_cyc && !top_match) |=> !o_ack && !o_check_init)
        else $error("answer with top bits unmatched");
    // Each address bit must differ from its closed-is-one segment
    dec_map_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        top_match == (
            (i_addr[ADDR_TOP_HI] != i_ecc_board_config_switch[SEG_DEC_LO]) &&
            (i_addr[ADDR_TOP_HI-1] !=
                i_ecc_board_config_switch[SEG_DEC_LO+1]) &&
            (i_addr[ADDR_TOP_LO] != i_ecc_board_config_switch[SEG_DEC_HI])))
        else $error("decode segments mismatched");
    // Segment two always means board zero
    board_zero_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ecc_board_config_switch[SEG_BOARD_LO] |-> board_num == 3'h0)
        else $error("segment two not board zero");
    // Segment five alone means board three
    board_three_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ecc_board_config_switch[SEG_BOARD_HI:SEG_BOARD_LO] == 4'h8) |->
        board_num == 3'h3)
        else $error("segment five not board three");
    // All board segments open selects no board
    board_none_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ecc_board_config_switch[SEG_BOARD_HI:SEG_BOARD_LO] == 4'h0) |->
        board_num[2])
        else $error("board selected with all open");
    // Board one answers in the window below board zero
    board_one_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (new_cyc && top_match &&
        i_ecc_board_config_switch[SEG_BOARD_HI:SEG_BOARD_LO] == 4'h2 &&
        i_addr[ADDR_BRD_HI:ADDR_BRD_LO] == 2'h2) |=> o_ack)
        else $error("board one window not answered");
    // Valid flag follows the board segments one cycle later
    board_valid_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> o_board_valid ==
        $past(|i_ecc_board_config_switch[SEG_BOARD_HI:SEG_BOARD_LO]))
        else $error("board valid flag wrong");
    // Reset leaves every output quiet and at its reset value
    reset_quiet_a: assert property (
        @(posedge i_clk)
        !i_rst_n |=> !o_ack && !o_check_init && !o_board_valid &&
        o_rdata == '0 && o_csr == CSR_RESET &&
        o_diag_a == DATA_WIDTH'(DIAG_RESET))
        else $error("outputs not quiet in reset");
endmodule

// *** hw/ecc_decode_pkg.sv ***
// Constants shared by the ECC board control-location decoder
package ecc_decode_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CSR_RESET_W = 32;
    localparam logic [31:0] CSR_RESET = 32'h00000000;
    localparam logic [31:0] DIAG_RESET = 32'h00000000;
    // Switch segment positions, bit 0 is segment one
    localparam int SEG_UNUSED = 0;
    localparam int SEG_BOARD_LO = 1;
    localparam int SEG_BOARD_HI = 4;
    localparam int SEG_DEC_LO = 5;
    localparam int SEG_DEC_HI = 7;
    // Address fields
    localparam int ADDR_TOP_HI = 31;
    localparam int ADDR_TOP_LO = 29;
    localparam int ADDR_SEL_BIT = 2;
    // Board window bits A23:A22 select a board (4MB each)
    localparam int ADDR_BRD_HI = 23;
    localparam int ADDR_BRD_LO = 22;
    // Register offsets within the control window
    localparam logic [31:0] OFS_CSR = 32'hE0C00000;
    localparam logic [31:0] OFS_DIAG = 32'hE0C00004;
    // Check bit initialization pulse length in cycles
    localparam int INIT_PULSE_CYC = 1;
endpackage

// *** hw/ecc_diag_latch.sv ***
// Diagnostic latch pair for the two error correction chips
`timescale 1ns/10ps
module ecc_diag_latch #(
    parameter int WIDTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [WIDTH-1:0] i_data,
    output logic [WIDTH-1:0] o_latch_a,
    output logic [WIDTH-1:0] o_latch_b
);
    import ecc_decode_pkg::*;

    initial begin
        if (WIDTH < 1) $error("WIDTH must be positive");
    end

    typedef struct packed {
        logic [WIDTH-1:0] a;
        logic [WIDTH-1:0] b;
    } latch_state_type;

    latch_state_type s_q;
    latch_state_type s_d;

    // Both chips load from one write so they never disagree
    always_comb begin
        s_d = s_q;
        if (i_we) begin
            s_d.a = i_data;
            s_d.b = i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q.a <= WIDTH'(DIAG_RESET);
            s_q.b <= WIDTH'(DIAG_RESET);
        end else begin
            s_q <= s_d;
        end
    end

    assign o_latch_a = s_q.a;
    assign o_latch_b = s_q.b;

    same_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_we |=> (o_latch_a == $past(i_data)) && (o_latch_b == o_latch_a))
        else $error("latch pair not loaded together");
endmodule

// *** tb/bus_master_model.sv ***
// Slave bus master model that drives one decoder access at a time
`timescale 1ns/10ps
module bus_master_model (
    input wire logic i_clk,
    input wire logic i_ack,
    input wire logic [31:0] i_rdata,
    input wire logic i_check_init,
    output logic o_cyc,
    output logic o_we,
    output logic [31:0] o_addr,
    output logic [31:0] o_wdata
);
    logic got_ack = 1'b0;
    logic got_init = 1'b0;
    logic [31:0] got_data = 32'h0;
    initial begin
        o_cyc = 1'b0;
        o_we = 1'b0;
        o_addr = 32'h0;
        o_wdata = 32'h0;
    end
    // One access; boards sit 4MB apart in the map
    task automatic access(input logic we, input logic [31:0] addr,
        input logic [31:0] data);
        got_ack = 1'b0;
        got_init = 1'b0;
        got_data = 32'h0;
        @(posedge i_clk);
        #1;
        o_cyc = 1'b1;
        o_we = we;
        o_addr = addr;
        o_wdata = data;
        // Bounded wait, a refused access never answers
        for (int n = 0; n < 3 && !got_ack; n++) begin
            @(posedge i_clk);
            #1;
            if (i_ack === 1'b1) begin
                got_ack = 1'b1;
                got_data = i_rdata;
                got_init = i_check_init;
                @(posedge i_clk);
                #1;
            end
        end
        // Released lines show the inverse, not a stale value
        o_cyc = 1'b0;
        o_we = ~o_we;
        o_addr = ~o_addr;
        o_wdata = ~o_wdata;
    endtask
endmodule

// *** tb/ecc_csr_decode_test.sv ***
// Self-checking bench for the ECC board control-location decoder
`timescale 1ns/10ps
module ecc_csr_decode_test;
    import ecc_decode_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sw = 8'h02;
    logic cyc, we, ack, init, valid;
    logic [31:0] addr, wdata, rdata, csr, dga, dgb;
    int fails = 0;
    int num_checks = 0;
    always #12.5 clk = ~clk;
    ecc_csr_decode u_dut (.i_clk(clk), .i_rst_n(rst_n),
        .i_ecc_board_config_switch(sw), .i_cyc(cyc), .i_we(we),
        .i_addr(addr), .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata),
        .o_csr(csr), .o_diag_a(dga), .o_diag_b(dgb),
        .o_check_init(init), .o_board_valid(valid));
    bus_master_model u_bm (.i_clk(clk), .i_ack(ack), .i_rdata(rdata),
        .i_check_init(init), .o_cyc(cyc), .o_we(we), .o_addr(addr),
        .o_wdata(wdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Board 0 only, decode left open
    task automatic t_csr();
        chk(csr, 32'h0);
        u_bm.access(1'b1, 32'hE0C00000, 32'hA5A51234);
        chk(u_bm.got_ack, 32'h1);
        chk(csr, 32'hA5A51234);
        u_bm.access(1'b0, 32'hE0C00000, 32'h0);
        chk(u_bm.got_data, 32'hA5A51234);
    endtask
    // Latch write leaves the control register alone; read starts init
    task automatic t_diag();
        u_bm.access(1'b1, 32'hE0C00004, 32'h5A5AC3C3);
        chk(dga, 32'h5A5AC3C3);
        chk(dgb, 32'h5A5AC3C3);
        chk(csr, 32'hA5A51234);
        u_bm.access(1'b0, 32'hE0C00004, 32'h0);
        chk(u_bm.got_init, 32'h1);
        chk(u_bm.got_data, 32'h0);
    endtask
    // Each position answers only in its own window; segment one closed
    task automatic t_boards();
        logic [31:0] a;
        for (int n = 0; n < 4; n++) begin
            sw = 8'h01 | (8'h02 << n);
            a = 32'hE0C00000 - 32'(n) * 32'h00400000;
            u_bm.access(1'b1, a, 32'h100 + 32'(n));
            chk(u_bm.got_ack, 32'h1);
            chk(csr, 32'h100 + 32'(n));
            chk(valid, 32'h1);
            u_bm.access(1'b1, a ^ 32'h00400000, 32'hFFFF);
            chk(u_bm.got_ack, 32'h0);
            chk(csr, 32'h100 + 32'(n));
        end
    endtask
    // Closed segment six moves the match to A31 low
    task automatic t_decode();
        sw = 8'h22;
        u_bm.access(1'b1, 32'h60C00000, 32'h0000BEEF);
        chk(u_bm.got_ack, 32'h1);
        chk(csr, 32'h0000BEEF);
        u_bm.access(1'b1, 32'hE0C00000, 32'h1);
        chk(u_bm.got_ack, 32'h0);
        sw = 8'hE0;
        u_bm.access(1'b1, 32'h00C00000, 32'h1);
        chk(u_bm.got_ack, 32'h0);
        chk(valid, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_csr();
        t_diag();
        t_boards();
        t_decode();
        final_report();
    end
    // Whole run needs about 53 cycles
    initial begin
        #(25 * 600);
        fails++;
        final_report();
    end
endmodule
